// *** shared/fl_pkg.sv ***
// Frequency limit and jump: shared constants and types.
// Frequencies are unsigned 16-bit values in units of 0.1 Hz.
package fl_pkg;

	// Register byte offsets on the Wishbone bus
	localparam logic [7:0] OFS_UPPER  = 8'h00;
	localparam logic [7:0] OFS_LOWER  = 8'h04;
	localparam logic [7:0] OFS_HIGH   = 8'h08;
	localparam logic [7:0] OFS_JUMP0  = 8'h0C;
	localparam logic [7:0] OFS_WIDTH  = 8'h24;
	localparam logic [7:0] OFS_JOG    = 8'h28;
	localparam logic [7:0] OFS_START  = 8'h2C;
	localparam logic [7:0] OFS_GAIN   = 8'h30;
	localparam logic [7:0] OFS_CTRL   = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_SETF   = 8'h3C;

	// Number of jump points (three A/B pairs)
	localparam int JUMP_POINTS = 6;

	// Field positions
	localparam int CTRL_SENSORLESS = 0;
	localparam int STAT_WRITE_ERR  = 0;
	localparam int STAT_JUMP_HIT   = 1;
	localparam int STAT_DIR_UP     = 2;

	// Setting limits
	localparam logic [15:0] LIMIT_NORMAL_MAX = 16'h04B0;
	localparam logic [15:0] LIMIT_HIGH_MAX   = 16'h170C;
	localparam logic [15:0] LIMIT_WIDTH_MAX  = 16'h012C;
	localparam logic [15:0] SETTING_DISABLED = 16'h270F;

	// Reset values
	localparam logic [15:0] RST_UPPER = 16'h04B0;
	localparam logic [15:0] RST_LOWER = 16'h0000;
	localparam logic [15:0] RST_JUMP  = 16'h270F;
	localparam logic [15:0] RST_WIDTH = 16'h270F;
	localparam logic [15:0] RST_JOG   = 16'h0032;
	localparam logic [15:0] RST_START = 16'h0005;
	localparam logic [15:0] RST_GAIN  = 16'h0258;

	// Frequency command from the source
	typedef struct packed {
		logic        present;
		logic        jog;
		logic        analog;
		logic [15:0] freq;
	} fl_cmd_s;

	// Packed set of six jump points
	typedef logic [JUMP_POINTS-1:0][15:0] fl_points_t;

endpackage

// *** logic/fl_freq_limit_jump.sv ***
`timescale 1ns/1ps

module fl_freq_limit_jump
	import fl_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Command source and start input
	input  wire fl_cmd_s     cmdIn,
	input  wire logic        startOn,
	// Stall prevention path
	input  wire logic        stallActive,
	input  wire logic [15:0] stallFreq,
	// Drive side
	output logic      [15:0] setFreq,
	output logic      [15:0] stallOut,
	output logic             jumpHit,
	output logic             paramWriteError
);

	// Settings
	logic [15:0] upperLimit;     // Shared normal / high-speed maximum
	logic [15:0] lowerLimit;     // Minimum frequency
	fl_points_t  jumpPt;         // Jump points 1A,1B,2A,2B,3A,3B
	logic [15:0] jumpWidth;      // Common jump range width
	logic [15:0] jogSpeed;       // Jog frequency
	logic [15:0] startSpeed;     // Starting frequency
	logic [15:0] analogGain;     // Analog full-scale frequency
	logic        sensorless;     // Sensorless vector control selected
	logic        dirUp;          // Last seen direction of the target
	logic [15:0] prevBase;       // Previous clamped command

	// Larger of two values
	function automatic logic [15:0] maxOf(input logic [15:0] a,
		input logic [15:0] b);
		maxOf = (a > b) ? a : b;
	endfunction

	// Smaller of two values
	function automatic logic [15:0] minOf(input logic [15:0] a,
		input logic [15:0] b);
		minOf = (a < b) ? a : b;
	endfunction

	// A point is in use unless it holds the disable code
	function automatic logic ptOn(input logic [15:0] v);
		ptOn = (v != SETTING_DISABLED);
	endfunction

	// True when any two enabled A/B pair ranges overlap
	// Bounds are inclusive, so touching ranges count as overlap
	function automatic logic pairsOverlap(input fl_points_t p);
		logic [2:0]       on;
		logic [2:0][15:0] lo;
		logic [2:0][15:0] hi;
		pairsOverlap = 1'b0;
		for (int i = 0; i < 3; i++) begin
			on[i] = ptOn(p[2*i]) & ptOn(p[2*i+1]);
			lo[i] = minOf(p[2*i], p[2*i+1]);
			hi[i] = maxOf(p[2*i], p[2*i+1]);
		end
		for (int i = 0; i < 3; i++) begin
			for (int j = i + 1; j < 3; j++) begin
				if (on[i] && on[j] && lo[i] <= hi[j] && lo[j] <= hi[i]) begin
					pairsOverlap = 1'b1;
				end
			end
		end
	endfunction

	// Three-area jump: inside a pair range the A point is used
	// A point picks top or bottom bound
	function automatic logic [16:0] jump3(input logic [15:0] v,
		input fl_points_t p);
		logic [15:0] lo;
		logic [15:0] hi;
		logic        hit;
		hit   = 1'b0;
		jump3 = {1'b0, v};
		for (int i = 2; i >= 0; i--) begin
			lo = minOf(p[2*i], p[2*i+1]);
			hi = maxOf(p[2*i], p[2*i+1]);
			if (ptOn(p[2*i]) && ptOn(p[2*i+1]) && v >= lo && v <= hi) begin
				hit   = 1'b1;
				jump3 = {hit, p[2*i]};
			end
		end
	endfunction

	// Six-area jump with merging of overlapping areas
	function automatic logic [16:0] jump6(input logic [15:0] v,
		input logic up, input fl_points_t p, input logic [15:0] w);
		logic [15:0] lo;
		logic [15:0] hi;
		logic [15:0] x;
		logic        hit;
		x   = v;
		hit = 1'b0;
		// Repeated passes walk across chains of overlapping areas
		for (int pass = 0; pass < JUMP_POINTS; pass++) begin
			for (int i = 0; i < JUMP_POINTS; i++) begin
				// Area spans point minus to plus width
				lo = (p[i] > w) ? p[i] - w : 16'h0000;
				hi = p[i] + w;
				if (ptOn(p[i]) && x >= lo && x <= hi) begin
					hit = 1'b1;
					x   = up ? minOf(x, lo) : maxOf(x, hi);
				end
			end
		end
		jump6 = {hit, x};
	endfunction

	// Register read selection
	function automatic logic [15:0] readReg(input logic [7:0] a);
		readReg = 16'h0000;
		case (a)
			OFS_UPPER:  readReg = upperLimit;
			// Both maximum addresses read the shared value
			OFS_HIGH:   readReg = upperLimit;
			OFS_LOWER:  readReg = lowerLimit;
			OFS_WIDTH:  readReg = jumpWidth;
			OFS_JOG:    readReg = jogSpeed;
			OFS_START:  readReg = startSpeed;
			OFS_GAIN:   readReg = analogGain;
			OFS_CTRL:   readReg = {15'h0000, sensorless};
			OFS_STATUS: readReg = {13'h0000, dirUp, jumpHit,
				paramWriteError};
			OFS_SETF:   readReg = setFreq;
			default: begin
				for (int i = 0; i < JUMP_POINTS; i++) begin
					if (a == OFS_JUMP0 + 8'(4 * i)) begin
						readReg = jumpPt[i];
					end
				end
			end
		endcase
	endfunction

	// Bus decode
	wire         busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire         busWr   = busReq & wb_we_i;
	// Current register value; a process re-runs the read mux when
	// any register changes, a plain assign follows the address only
	logic [15:0] curVal;
	always_comb begin
		curVal = readReg(wb_adr_i);
	end
	// Byte lanes 0 and 1 merge into the current value
	wire  [15:0] wrVal   = {wb_sel_i[1] ? wb_dat_i[15:8] : curVal[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : curVal[7:0]};
	wire         wrUpper = busWr & (wb_adr_i == OFS_UPPER);
	wire         wrHigh  = busWr & (wb_adr_i == OFS_HIGH);
	wire         wrLower = busWr & (wb_adr_i == OFS_LOWER);
	wire         wrWidth = busWr & (wb_adr_i == OFS_WIDTH);
	wire         wrStat  = busWr & (wb_adr_i == OFS_STATUS);

	// Jump point writes and candidate point set
	// A write is judged on the whole set as it would become
	logic [JUMP_POINTS-1:0] wrJump;
	fl_points_t             candPt;
	genvar g;
	generate
		for (g = 0; g < JUMP_POINTS; g++) begin : gJump
			assign wrJump[g] = busWr & (wb_adr_i == OFS_JUMP0 + 8'(4 * g));
			assign candPt[g] = wrJump[g] ? wrVal : jumpPt[g];
		end
	endgenerate
	wire anyJumpWr = |wrJump;

	// Range checks on maximum, minimum, jump point and width writes
	// A refused write is still acknowledged; only the sticky error
	// flag tells software that the value did not land
	// Normal and high-speed maximum ranges
	wire badUpper = wrUpper & (wrVal > LIMIT_NORMAL_MAX);
	wire badHigh  = wrHigh & (wrVal > LIMIT_HIGH_MAX);
	wire badLower = wrLower & (wrVal > LIMIT_NORMAL_MAX);
	// Jump point range or disable code
	wire badJumpV = anyJumpWr & ptOn(wrVal) & (wrVal > LIMIT_HIGH_MAX);
	wire badJumpO = anyJumpWr & pairsOverlap(candPt);
	wire badWidth = wrWidth & ptOn(wrVal) & (wrVal > LIMIT_WIDTH_MAX);
	wire badWrite = badUpper | badHigh | badLower | badJumpV | badJumpO
		| badWidth;

	// Error flag, set wins over clear
	// Writing one to status bit 0 clears it
	wire next_paramWriteError = badWrite |
		(paramWriteError & ~(wrStat & wrVal[STAT_WRITE_ERR]));

	// Command preparation
	// Minimum acts on the command only; stall may drop below it
	// Analog command capped at analog gain frequency
	wire [15:0] rawCmd  = cmdIn.analog ? minOf(cmdIn.freq, analogGain)
		: cmdIn.freq;
	wire [15:0] hiClamp = minOf(rawCmd, upperLimit);
	wire [15:0] baseCmd = maxOf(hiClamp, lowerLimit);

	// Direction of the clamped command
	// Compared with last cycle's command, not the ramp, so the bound
	// follows the target; a steady command keeps the last direction
	wire next_dirUp = (baseCmd > prevBase) ? 1'b1 :
		(baseCmd < prevBase) ? 1'b0 : dirUp;

	// Jump mode selection
	// Width at the disable code keeps three-area mode
	// Width zero turns jumping off
	wire        jumpsOn = (jumpWidth != 16'h0000);
	// Width other than zero and the disable code selects six areas
	wire        sixMode = jumpsOn & ptOn(jumpWidth);
	wire [16:0] res3    = jump3(baseCmd, jumpPt);
	wire [16:0] res6    = jump6(baseCmd, next_dirUp, jumpPt, jumpWidth);
	wire [16:0] resJmp  = !jumpsOn ? {1'b0, baseCmd} :
		sixMode ? res6 : res3;
	// Jump target above maximum uses maximum, below minimum stays
	wire [15:0] jmpCmd  = minOf(resJmp[15:0], upperLimit);

	// Jog path
	// Jog skips the jump areas
	// Jog at or below minimum is used as set
	wire [15:0] jogCmd  = (jogSpeed <= lowerLimit) ? jogSpeed
		: minOf(jogSpeed, upperLimit);

	// No-command path
	// Start input alone, with no command present
	// Start alone runs at minimum when minimum reaches start level
	wire [15:0] idleCmd = (startOn && lowerLimit >= startSpeed) ?
		lowerLimit : 16'h0000;

	// Final target selection
	// Jog first, then the no-command case, then normal
	// Only the target jumps; the ramp downstream crosses areas
	wire [15:0] next_setFreq = cmdIn.jog ? jogCmd :
		!cmdIn.present ? idleCmd : jmpCmd;
	wire        next_jumpHit = ~cmdIn.jog & cmdIn.present & resJmp[16];

	// Stall-lowered frequency
	// Follows the target whenever stall is not acting
	// Stall may drop below minimum; only the maximum applies
	// Sensorless control leaves limits on the command only
	wire [15:0] next_stallOut = (stallActive & ~sensorless) ?
		minOf(stallFreq, upperLimit) : next_setFreq;

	// Bus answer: ack one cycle after the request, then dropped
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			// One ack per request; the ack itself masks a second take
			wb_ack_o <= busReq;
			// Data only beside the ack, zero otherwise
			wb_dat_o <= busReq ? {16'h0000, curVal} : 32'h0000_0000;
		end
	end

	// Shared maximum storage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// One register serves both maximum addresses
			upperLimit <= RST_UPPER;
		end else if ((wrUpper & ~badUpper) | (wrHigh & ~badHigh)) begin
			upperLimit <= wrVal;
		end
	end

	// Minimum, width and miscellaneous settings
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// Defaults: no minimum, jumps in three-area mode
			lowerLimit <= RST_LOWER;
			jumpWidth  <= RST_WIDTH;
			jogSpeed   <= RST_JOG;
			startSpeed <= RST_START;
			analogGain <= RST_GAIN;
			sensorless <= 1'b0;
		end else begin
			// Minimum, refused above the normal range
			if (wrLower & ~badLower) begin
				lowerLimit <= wrVal;
			end
			// Width; zero and the disable code both accepted
			if (wrWidth & ~badWidth) begin
				jumpWidth <= wrVal;
			end
			// Jog frequency, taken as written
			if (busWr & (wb_adr_i == OFS_JOG)) begin
				jogSpeed <= wrVal;
			end
			// Starting frequency for the start-alone check
			if (busWr & (wb_adr_i == OFS_START)) begin
				startSpeed <= wrVal;
			end
			if (busWr & (wb_adr_i == OFS_GAIN)) begin
				analogGain <= wrVal;
			end
			// Control bits
			if (busWr & (wb_adr_i == OFS_CTRL)) begin
				sensorless <= wrVal[CTRL_SENSORLESS];
			end
		end
	end

	// Jump points: whole set updates only on a legal write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// All six points start disabled
			jumpPt <= {JUMP_POINTS{RST_JUMP}};
		end else if (anyJumpWr & ~badJumpV & ~badJumpO) begin
			jumpPt <= candPt;
		end
	end

	// Target, flags and direction tracking
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// Nothing runs until a command arrives
			setFreq         <= 16'h0000;
			stallOut        <= 16'h0000;
			jumpHit         <= 1'b0;
			paramWriteError <= 1'b0;
			dirUp           <= 1'b1;
			prevBase        <= 16'h0000;
		end else begin
			// Target and stall outputs, both registered
			setFreq         <= next_setFreq;
			stallOut        <= next_stallOut;
			// Flags for the drive side and status
			jumpHit         <= next_jumpHit;
			paramWriteError <= next_paramWriteError;
			// Direction picks lower or upper bound
			dirUp           <= next_dirUp;
			prevBase        <= baseCmd;
		end
	end

endmodule

// *** sim/fl_cmd_source.sv ***
`timescale 1ns/1ps
// Upstream command source: one register stage, like a real source
module fl_cmd_source
	import fl_pkg::*;
(
	// Clock
	input  wire logic    core_clk,
	// Request from the bench
	input  wire fl_cmd_s reqCmd,
	// Command towards the block
	output fl_cmd_s      cmdOut
);
	// Launch each command one edge after it is asked for
	always_ff @(posedge core_clk) begin
		cmdOut <= reqCmd;
	end
endmodule

// *** sim/fl_freq_limit_jump_asserts.sv ***
`timescale 1ns/1ps
// Port-level checks of the bus and the command path
module fl_freq_limit_jump_asserts
	import fl_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Command path
	input wire fl_cmd_s     cmdIn,
	input wire logic        startOn,
	input wire logic        stallActive,
	input wire logic [15:0] setFreq,
	input wire logic [15:0] stallOut,
	input wire logic        paramWriteError
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Taken request, taken write, full 16-bit write and its value
	wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wr   = take && wb_we_i;
	wire        full = wr && (wb_sel_i[1:0] == 2'h3);
	wire [15:0] v    = wb_dat_i[15:0];

	property p_ack_next; take |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data idle");
	property p_up_bad;
		full && wb_adr_i == OFS_UPPER && v > LIMIT_NORMAL_MAX
		|=> paramWriteError;
	endproperty
	a_up_bad: assert property (p_up_bad) else $error("upper");
	property p_hi_bad;
		full && wb_adr_i == OFS_HIGH && v > LIMIT_HIGH_MAX
		|=> paramWriteError;
	endproperty
	a_hi_bad: assert property (p_hi_bad) else $error("high");
	property p_jp_bad;
		full && wb_adr_i >= OFS_JUMP0 && wb_adr_i < OFS_WIDTH
		&& wb_adr_i[1:0] == 2'h0
		&& v > LIMIT_HIGH_MAX && v != SETTING_DISABLED |=> paramWriteError;
	endproperty
	a_jp_bad: assert property (p_jp_bad) else $error("jump");
	property p_wd_bad;
		full && wb_adr_i == OFS_WIDTH && v > LIMIT_WIDTH_MAX
		&& v != SETTING_DISABLED |=> paramWriteError;
	endproperty
	a_wd_bad: assert property (p_wd_bad) else $error("width");
	property p_err_hold;
		paramWriteError && !(wr && wb_adr_i == OFS_STATUS)
		|=> paramWriteError;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("err");
	property p_idle;
		!cmdIn.present && !cmdIn.jog && !startOn |=> setFreq == 16'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_stall; !stallActive |=> stallOut == setFreq; endproperty
	a_stall: assert property (p_stall) else $error("stall");
endmodule

bind fl_freq_limit_jump fl_freq_limit_jump_asserts chk_u (
	.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmdIn, .startOn,
	.stallActive, .setFreq, .stallOut, .paramWriteError
);

// *** sim/fl_freq_limit_jump_tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for the frequency limit and jump block
module fl_freq_limit_jump_tb_top import fl_pkg::*;;
	// Clock, reset and bus
	logic        core_clk;
	logic        rst_n;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] datI;
	logic [31:0] datO;
	logic        ack;
	// Command path
	fl_cmd_s     reqCmd;
	fl_cmd_s     cmdIn;
	logic        startOn;
	logic        stallActive;
	logic [15:0] stallFreq;
	logic [15:0] setFreq;
	logic [15:0] stallOut;
	logic        jumpHit;
	logic        paramWriteError;
	// Bookkeeping
	int          errors;
	int          n_compared;

	fl_cmd_source src_u (.core_clk(core_clk), .reqCmd(reqCmd),
		.cmdOut(cmdIn));
	fl_freq_limit_jump dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
		.cmdIn(cmdIn), .startOn(startOn), .stallActive(stallActive),
		.stallFreq(stallFreq), .setFreq(setFreq), .stallOut(stallOut),
		.jumpHit(jumpHit), .paramWriteError(paramWriteError));

	// Clock at 50 MHz
	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end

	// Verdict and end of run
	task end_sim;
		if (errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One comparison
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	// One bus cycle, held until ack; returns read data
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int   k;
		logic got;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= s;
		datI <= {16'h0, d};
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		got = (ack === 1'h1);
		r = datO;
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge core_clk);
		if (!got) begin
			errors++;
			end_sim();
		end
	endtask

	// Register write, lane write, checked read and refused write
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, 4'h3, r);
	endtask
	task wrs(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		bus(1'h1, a, d, s, r);
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e, input string n);
		logic [31:0] r;
		bus(1'h0, a, 16'h0, 4'h3, r);
		chk(n, {16'h0, e}, r);
	endtask
	task bad(input logic [7:0] a, input logic [15:0] d, input string n);
		wr(a, d);
		chk(n, 1, paramWriteError);
		wr(OFS_STATUS, 16'h0001);
		chk({n, " clr"}, 0, paramWriteError);
	endtask

	// Apply a command and check the set frequency
	task cmd(input logic [2:0] m, input logic [15:0] f,
		input logic [15:0] e, input string n);
		reqCmd <= {m, f};
		repeat (3) @(posedge core_clk);
		chk(n, {16'h0, e}, {16'h0, setFreq});
	endtask

	// Limits, aliasing and refused values
	task t_limits;
		rdc(OFS_UPPER, RST_UPPER, "upper");
		rdc(OFS_JUMP0, RST_JUMP, "jump");
		rdc(OFS_WIDTH, RST_WIDTH, "width");
		rdc(8'h40, 16'h0, "unmapped");
		wr(OFS_UPPER, 16'h0258);
		rdc(OFS_HIGH, 16'h0258, "alias");
		cmd(3'h4, 16'h0384, 16'h0258, "max");
		wr(OFS_HIGH, 16'h0BB8);
		rdc(OFS_UPPER, 16'h0BB8, "alias2");
		cmd(3'h4, 16'h0FA0, 16'h0BB8, "high max");
		wr(OFS_LOWER, 16'h0064);
		cmd(3'h4, 16'h0032, 16'h0064, "min");
		cmd(3'h5, 16'h0384, 16'h0258, "analog");
		wr(OFS_GAIN, 16'h0320);
		cmd(3'h5, 16'h0384, 16'h0320, "gain");
		wr(OFS_UPPER, 16'h04B1);
		chk("err", 1, paramWriteError);
		rdc(OFS_UPPER, 16'h0BB8, "kept");
		wr(OFS_STATUS, 16'h0001);
		chk("clr", 0, paramWriteError);
		bad(OFS_HIGH, 16'h170D, "bad high");
		bad(OFS_LOWER, 16'h04B1, "bad lower");
		bad(OFS_JUMP0, 16'h170D, "bad jump");
		rdc(OFS_JUMP0, RST_JUMP, "jump kept");
		bad(OFS_WIDTH, 16'h012D, "bad width");
		rdc(OFS_UPPER, 16'h0BB8, "high kept");
		cmd(3'h2, 16'h0, RST_JOG, "jog");
		startOn <= 1'h1;
		cmd(3'h0, 16'h0, 16'h0064, "start");
		wr(OFS_START, 16'h00C8);
		cmd(3'h0, 16'h0, 16'h0, "start low");
		startOn <= 1'h0;
		cmd(3'h0, 16'h0, 16'h0, "idle");
		wrs(OFS_JOG, 16'hAB12, 4'h1);
		rdc(OFS_JOG, 16'h0012, "lane low");
		wrs(OFS_JOG, 16'hAB34, 4'h2);
		rdc(OFS_JOG, 16'hAB12, "lane high");
	endtask

	// Three-area jumps, clipping and overlapping pairs
	task t_three;
		wr(OFS_JUMP0, 16'h00C8);
		wr(OFS_JUMP0 + 8'h04, 16'h00FA);
		wr(OFS_JUMP0 + 8'h08, 16'h0190);
		wr(OFS_JUMP0 + 8'h0C, 16'h015E);
		cmd(3'h4, 16'h00DC, 16'h00C8, "area1");
		chk("hit", 1, jumpHit);
		rdc(OFS_SETF, 16'h00C8, "setf");
		rdc(OFS_STATUS, 16'h0006, "status");
		cmd(3'h4, 16'h0172, 16'h0190, "area2");
		wr(OFS_UPPER, 16'h017C);
		cmd(3'h4, 16'h0172, 16'h017C, "jmax");
		wr(OFS_UPPER, 16'h0BB8);
		wr(OFS_JUMP0 + 8'h10, 16'h0050);
		wr(OFS_JUMP0 + 8'h14, 16'h0078);
		cmd(3'h4, 16'h006E, 16'h0050, "jmin");
		wr(OFS_JUMP0 + 8'h10, RST_JUMP);
		wr(OFS_JUMP0 + 8'h14, RST_JUMP);
		wr(OFS_JUMP0 + 8'h14, 16'h00D2);
		wr(OFS_JUMP0 + 8'h10, 16'h00E6);
		chk("ovl", 1, paramWriteError);
		rdc(OFS_JUMP0 + 8'h10, RST_JUMP, "rej");
		wr(OFS_STATUS, 16'h0001);
		wr(OFS_JUMP0 + 8'h14, RST_JUMP);
	endtask

	// Six-area jumps, merging, direction and disable
	task t_six;
		wr(OFS_JUMP0 + 8'h04, 16'h00D2);
		wr(OFS_WIDTH, 16'h0014);
		cmd(3'h4, 16'h0064, 16'h0064, "base");
		cmd(3'h4, 16'h00D7, 16'h00B4, "rise");
		cmd(3'h4, 16'h012C, 16'h012C, "base2");
		cmd(3'h4, 16'h00D7, 16'h00E6, "fall");
		cmd(3'h4, 16'h0168, 16'h014A, "width");
		wr(OFS_WIDTH, 16'h0);
		cmd(3'h4, 16'h00D7, 16'h00D7, "off");
	endtask

	// Stall path below minimum, then sensorless
	task t_stall;
		stallFreq <= 16'h0032;
		stallActive <= 1'h1;
		repeat (3) @(posedge core_clk);
		chk("stall", 16'h0032, stallOut);
		wr(OFS_CTRL, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk("sless", 16'h00D7, stallOut);
		stallActive <= 1'h0;
	endtask

	// Main sequence
	initial begin
		errors = 0;
		n_compared = 0;
		rst_n = 1'h0;
		{cyc, stb, we, startOn, stallActive} = 5'h0;
		adr = 8'h0;
		sel = 4'h3;
		datI = 32'h0;
		stallFreq = 16'h0;
		reqCmd = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		t_limits();
		t_three();
		t_six();
		t_stall();
		end_sim();
	end
endmodule
